//--- design/ee24_pkg.sv
// Purpose: shared constants and types of the two-wire serial memory slave
// Assumes: system clock of 10 MHz; link logic on its own clock
// Notes:   slave address layout, page layout and program-cycle timing
package ee24_pkg;

  // slave address byte fields
  localparam int          SA_TYPE_MSB     = 7;
  localparam int          SA_TYPE_LSB     = 4;
  localparam int          SA_STRAP_HI_POS = 3;
  localparam int          SA_STRAP_LO_POS = 2;
  localparam int          SA_BLOCK_POS    = 1;
  localparam int          SA_RW_POS       = 0;
  localparam logic        RW_READ         = 1'b1;
  // device type code; value is arbitrary
  localparam logic [3:0]  DEV_TYPE_DEFAULT = 4'h5;

  // memory organisation
  localparam int          ADDR_W          = 9;
  localparam int          PAGE_W          = 4;
  localparam int          MEM_BYTES       = 512;
  localparam int          UPPER_HALF_POS  = 8;
  localparam logic [3:0]  BYTE_BITS       = 4'h8;

  // program cycle timing
  localparam int          SYS_CLK_KHZ     = 10000;
  localparam int          PROG_TIME_STD_US = 10000;
  localparam int          PROG_TIME_LP_US  = 15000;
  localparam int          PROG_CYC_STD    = PROG_TIME_STD_US * SYS_CLK_KHZ / 1000;
  localparam int          PROG_CYC_LP     = PROG_TIME_LP_US * SYS_CLK_KHZ / 1000;
  localparam int          PROG_CNT_W      = 18;

  typedef enum logic [10:0] {
    EE24_IDLE     = 11'h001,
    EE24_DEVADDR  = 11'h002,
    EE24_ACK_DEV  = 11'h004,
    EE24_WORDADDR = 11'h008,
    EE24_ACK_WORD = 11'h010,
    EE24_WRDATA   = 11'h020,
    EE24_ACK_DATA = 11'h040,
    EE24_RDDATA   = 11'h080,
    EE24_RDACK    = 11'h100,
    EE24_IGNORE   = 11'h200,
    EE24_BUSY     = 11'h400
  } ee24_state_e;

endpackage : ee24_pkg

//--- design/ee24_prog_timer.sv
// Purpose: self-timed program cycle counter in the system clock domain
// Assumes: request arrives as a toggle from the link domain
// Notes:   busy is a level, read back by the link through two flops
`timescale 1ns/1ns
module ee24_prog_timer
  import ee24_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC_STD
)(
  // system clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // request toggle from link domain
  input  wire logic req_tgl_in,
  // program cycle running
  output logic      busy_out
);
  import ee24_pkg::*;

  typedef struct packed {
    logic                  t_s1;
    logic                  t_s2;
    logic                  t_d;
    logic                  busy;
    logic [PROG_CNT_W-1:0] cnt;
  } ee24_tmr_s;

  ee24_tmr_s s_r;
  ee24_tmr_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.t_s1 = req_tgl_in;
    s_nxt.t_s2 = s_r.t_s1;
    s_nxt.t_d  = s_r.t_s2;
    if (reset_in) begin
      s_nxt.busy = 1'b0;
      s_nxt.cnt  = '0;
    end else if (s_r.t_s2 != s_r.t_d) begin
      s_nxt.busy = 1'b1; // R23
      s_nxt.cnt  = PROG_CNT_W'(PROG_CYCLES - 1);
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.busy = 1'b0; // R23
      end else begin
        s_nxt.cnt = s_r.cnt - PROG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    s_r <= s_nxt;
  end

  assign busy_out = s_r.busy;

endmodule : ee24_prog_timer

//--- design/ee24_slave.sv
// Purpose: two-wire serial memory slave, protocol engine on the link clock
// Assumes: scl and sda oversampled by link_clk_in, far faster than scl
// Notes:   sda is open drain: sda_out is low, sda_oe_out low pulls the line
//
// Functional notes
// [R1] transmitter releases after eight bits; receiver acks ninth
// [R2] acknowledge own slave address after start
// [R3] selected for write: ack every further byte
// [R4] read: release, sample ack, continue on ack
// [R5] no ack: stop sending, wait for stop
// [R6] top four address bits must equal type code
// [R7] strap bits match pins; next bit selects block
// [R8] last address bit one reads, zero writes
// [R9] write carries word address then data, each acked
// [R10] stop after data starts program; bus ignored meanwhile
// [R11] page write up to sixteen bytes, each acked
// [R12] counter advances per byte; overflow overwrites buffer
// [R13] polling: no ack while programming, ack after
// [R14] protected upper half: nack first data, no program
// [R15] counter holds last accessed address plus one
// [R16] current read: ack, send one byte, master nacks
// [R17] random read: dummy write then repeated start
// [R18] sequential read continues while master acks
// [R19] read increments all bits, wraps at end
// [R20] start is sda falling while scl high
// [R21] stop is sda rising while scl high
// [R22] sda changes only while scl low
// [R23] program cycle ends within 10 or 15 ms
// [R24] page write wraps only low four bits
// [R25] mismatch: stay released until next start
`timescale 1ns/1ns
module ee24_slave
  import ee24_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE    = DEV_TYPE_DEFAULT, // value is arbitrary
  parameter int         PROG_CYCLES = PROG_CYC_STD
)(
  // system clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // link clock
  input  wire logic link_clk_in,
  // two-wire bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  // straps and protection
  input  wire logic strap_addr_bit_low_in,
  input  wire logic strap_addr_bit_high_in,
  input  wire logic write_protect_in,
  // status
  output logic      prog_busy_out
);
  import ee24_pkg::*;

  typedef struct packed {
    logic                  rst_s1;
    logic                  rst_s2;
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_d;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_d;
    logic                  alo_s1;
    logic                  alo_s2;
    logic                  ahi_s1;
    logic                  ahi_s2;
    logic                  wp_s1;
    logic                  wp_s2;
    logic                  busy_s1;
    logic                  busy_s2;
    ee24_state_e           st;
    logic [3:0]            bitcnt;
    logic [7:0]            shreg;
    logic [ADDR_W-1:0]     addr;
    logic                  rw;
    logic [15:0][7:0]      pbuf;
    logic [15:0]           pvalid;
    logic [PAGE_W:0]       cidx;
    logic                  busy_seen;
    logic                  prog_tgl;
    logic                  sda_oe;
  } ee24_link_s;

  ee24_link_s        s_r;
  ee24_link_s        s_nxt;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic              addr_match;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [7:0]        rd_data;
  logic              timer_busy;

  // bus events from synchronised pins
  assign scl_rise  = s_r.scl_s2 & ~s_r.scl_d;
  assign scl_fall  = ~s_r.scl_s2 & s_r.scl_d;
  assign start_det = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;   // R20 R22
  assign stop_det  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;   // R21 R22

  assign addr_match = (s_r.shreg[SA_TYPE_MSB:SA_TYPE_LSB] == DEV_TYPE) // R6
                    & (s_r.shreg[SA_STRAP_HI_POS] == s_r.ahi_s2)       // R7
                    & (s_r.shreg[SA_STRAP_LO_POS] == s_r.alo_s2);      // R7

  // commit of the page buffer while the program cycle runs
  assign wr_en   = (s_r.st == EE24_BUSY) & ~s_r.cidx[PAGE_W]
                 & s_r.pvalid[s_r.cidx[PAGE_W-1:0]];                   // R10
  assign wr_addr = {s_r.addr[ADDR_W-1:PAGE_W], s_r.cidx[PAGE_W-1:0]};
  assign wr_data = s_r.pbuf[s_r.cidx[PAGE_W-1:0]];

  always_comb begin
    s_nxt         = s_r;
    s_nxt.rst_s1  = reset_in;
    s_nxt.rst_s2  = s_r.rst_s1;
    s_nxt.scl_s1  = scl_in;
    s_nxt.scl_s2  = s_r.scl_s1;
    s_nxt.scl_d   = s_r.scl_s2;
    s_nxt.sda_s1  = sda_in;
    s_nxt.sda_s2  = s_r.sda_s1;
    s_nxt.sda_d   = s_r.sda_s2;
    s_nxt.alo_s1  = strap_addr_bit_low_in;
    s_nxt.alo_s2  = s_r.alo_s1;
    s_nxt.ahi_s1  = strap_addr_bit_high_in;
    s_nxt.ahi_s2  = s_r.ahi_s1;
    s_nxt.wp_s1   = write_protect_in;
    s_nxt.wp_s2   = s_r.wp_s1;
    s_nxt.busy_s1 = timer_busy;
    s_nxt.busy_s2 = s_r.busy_s1;

    if (s_r.st == EE24_BUSY) begin
      // bus ignored: no ack, so polling sees nothing until done
      s_nxt.sda_oe = 1'b1; // R10 R13
      // walk the page buffer, one slot per link cycle
      if (!s_r.cidx[PAGE_W]) begin
        s_nxt.cidx = s_r.cidx + (PAGE_W+1)'(1);
      end
      // leave only after the timer was seen busy and idle again
      if (s_r.busy_s2) begin
        s_nxt.busy_seen = 1'b1;
      end
      if (s_r.cidx[PAGE_W] && s_r.busy_seen && !s_r.busy_s2) begin
        s_nxt.st     = EE24_IDLE; // R13
        s_nxt.pvalid = '0;
      end
    end else if (start_det) begin
      s_nxt.st     = EE24_DEVADDR; // R20
      s_nxt.bitcnt = '0;
      s_nxt.sda_oe = 1'b1;
      s_nxt.pvalid = '0;
    end else if (stop_det) begin
      s_nxt.sda_oe = 1'b1; // R21
      // only a stop after acked data programs; partial bytes dropped
      if (((s_r.st == EE24_WRDATA) || (s_r.st == EE24_ACK_DATA)) && (|s_r.pvalid)) begin
        s_nxt.st        = EE24_BUSY; // R10
        s_nxt.cidx      = '0;
        s_nxt.busy_seen = 1'b0;
        s_nxt.prog_tgl  = ~s_r.prog_tgl;
      end else begin
        s_nxt.st = EE24_IDLE; // R5 R16
      end
    end else begin
      // bits are taken on scl rise and driven after scl fall
      if (scl_rise) begin
        case (s_r.st)
          EE24_DEVADDR, EE24_WORDADDR, EE24_WRDATA: begin
            s_nxt.shreg  = {s_r.shreg[6:0], s_r.sda_s2};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end
          EE24_RDDATA: begin
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end
          EE24_RDACK: begin
            if (s_r.sda_s2) begin
              s_nxt.st = EE24_IGNORE; // R5
            end
          end
          default: begin
          end
        endcase
      end
      if (scl_fall) begin
        case (s_r.st)
          EE24_DEVADDR: begin
            if (s_r.bitcnt == BYTE_BITS) begin
              if (addr_match) begin
                s_nxt.sda_oe = 1'b0; // R1 R2 R13
                s_nxt.st     = EE24_ACK_DEV;
                s_nxt.rw     = s_r.shreg[SA_RW_POS]; // R8
                s_nxt.addr[UPPER_HALF_POS] = s_r.shreg[SA_BLOCK_POS]; // R7
              end else begin
                s_nxt.st = EE24_IGNORE; // R25
              end
            end
          end
          EE24_WORDADDR: begin
            if (s_r.bitcnt == BYTE_BITS) begin
              s_nxt.sda_oe     = 1'b0; // R3 R9
              s_nxt.st         = EE24_ACK_WORD;
              s_nxt.addr[7:0]  = s_r.shreg; // R9 R17
            end
          end
          EE24_WRDATA: begin
            if (s_r.bitcnt == BYTE_BITS) begin
              if ((s_r.pvalid == '0) && s_r.wp_s2 && s_r.addr[UPPER_HALF_POS]) begin
                s_nxt.st = EE24_IGNORE; // R14
              end else begin
                s_nxt.sda_oe = 1'b0; // R3 R11
                s_nxt.st     = EE24_ACK_DATA;
                s_nxt.pbuf[s_r.addr[PAGE_W-1:0]]   = s_r.shreg; // R12
                s_nxt.pvalid[s_r.addr[PAGE_W-1:0]] = 1'b1;
                s_nxt.addr[PAGE_W-1:0] = s_r.addr[PAGE_W-1:0] + PAGE_W'(1); // R12 R15 R24
              end
            end
          end
          EE24_ACK_DEV: begin
            s_nxt.bitcnt = '0;
            if (s_r.rw == RW_READ) begin
              s_nxt.st     = EE24_RDDATA; // R16
              s_nxt.shreg  = rd_data;
              s_nxt.sda_oe = rd_data[7];
            end else begin
              s_nxt.st     = EE24_WORDADDR;
              s_nxt.sda_oe = 1'b1; // R1
            end
          end
          EE24_ACK_WORD, EE24_ACK_DATA: begin
            s_nxt.bitcnt = '0;
            s_nxt.st     = EE24_WRDATA;
            s_nxt.sda_oe = 1'b1; // R1
          end
          EE24_RDDATA: begin
            if (s_r.bitcnt == BYTE_BITS) begin
              s_nxt.sda_oe = 1'b1; // R1 R4
              s_nxt.st     = EE24_RDACK;
              s_nxt.addr   = s_r.addr + ADDR_W'(1); // R15 R19
            end else begin
              s_nxt.shreg  = {s_r.shreg[6:0], 1'b0};
              s_nxt.sda_oe = s_r.shreg[6];
            end
          end
          EE24_RDACK: begin
            s_nxt.st     = EE24_RDDATA; // R4 R18
            s_nxt.bitcnt = '0;
            s_nxt.shreg  = rd_data;
            s_nxt.sda_oe = rd_data[7];
          end
          default: begin
          end
        endcase
      end
    end

    // link-side reset from the synchronised system reset
    if (s_r.rst_s2) begin
      s_nxt.st        = EE24_IDLE;
      s_nxt.bitcnt    = '0;
      s_nxt.shreg     = '0;
      s_nxt.addr      = '0;
      s_nxt.rw        = 1'b0;
      s_nxt.pvalid    = '0;
      s_nxt.cidx      = '0;
      s_nxt.busy_seen = 1'b0;
      s_nxt.prog_tgl  = 1'b0;
      s_nxt.sda_oe    = 1'b1;
    end
  end

  always_ff @(posedge link_clk_in) begin
    s_r <= s_nxt;
  end

  // byte array, written only by the commit walk
  ee24_store u_store (
    .clk_in      (link_clk_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (wr_addr),
    .wr_data_in  (wr_data),
    .rd_addr_in  (s_r.addr),
    .rd_data_out (rd_data)
  );

  // program cycle timer on the system clock
  ee24_prog_timer #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .req_tgl_in (s_r.prog_tgl),
    .busy_out   (timer_busy)
  );

  // open drain: only the enable moves, drive value fixed low
  assign sda_out       = 1'b0;
  assign sda_oe_out    = s_r.sda_oe;
  assign prog_busy_out = timer_busy;

endmodule : ee24_slave

//--- design/ee24_store.sv
// Purpose: byte array of the serial memory, one write and one read port
// Assumes: link clock domain only
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/1ns
module ee24_store
  import ee24_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // write port
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [7:0]        wr_data_in,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [7:0]        rd_data_out
);
  import ee24_pkg::*;

  logic [7:0] mem_r [0:MEM_BYTES-1];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end

endmodule : ee24_store

//--- tb/ee24_master.sv
// Purpose: behavioural two-wire bus master facing the memory slave
// Assumes: open-drain wire resolved by the bench, pull-up when released
// Notes:   quarter bit is five system clocks, lines move at falling edges
`timescale 1ns/1ns
module ee24_master (
  // pacing clock
  input  wire logic clk_in,
  // two-wire bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hp;
    repeat (5) @(negedge clk_in);
  endtask : hp
  // start or repeated start
  task automatic start_cond;
    sda_out = 1'b1;
    hp();
    scl_out = 1'b1;
    hp();
    sda_out = 1'b0;
    hp();
    scl_out = 1'b0;
    hp();
  endtask : start_cond
  task automatic stop_cond;
    sda_out = 1'b0;
    hp();
    scl_out = 1'b1;
    hp();
    sda_out = 1'b1;
    hp();
    hp();
  endtask : stop_cond
  // eight bits msb first, ninth is the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack_rx);
    logic [8:0] sh;
    sh = {tx, ack_tx};
    for (int i = 8; i >= 0; i--) begin
      sda_out = sh[i];
      hp();
      scl_out = 1'b1;
      hp();
      sh[i] = sda_in;
      hp();
      scl_out = 1'b0;
      hp();
    end
    rx = sh[8:1];
    ack_rx = sh[0];
  endtask : xfer
endmodule : ee24_master

//--- tb/ee24_slave_properties.sv
// Purpose: bus and program-cycle properties of the serial memory slave
// Assumes: raw bus levels, engine oversamples them on the link clock
// Notes:   bound into every instance of the slave
`timescale 1ns/1ns
module ee24_slave_properties #(
  parameter int PROG_CYCLES = 20
)(
  // clocks and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  // bus and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic prog_busy_out
);
  int unsigned busy_cnt_r;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !prog_busy_out) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_r + 1;
  end

  drive_low_a:
    assert property (@(posedge link_clk_in) disable iff (reset_in)
      !sda_oe_out |-> sda_out == 1'b0 && !sda_in) else $error("sda drive did not pull low");
  scl_high_stable_a:
    assert property (@(posedge link_clk_in) disable iff (reset_in)
      $changed(sda_oe_out) |-> !scl_in) else $error("sda moved while scl high");
  sync_delay_a:
    assert property (@(posedge link_clk_in) disable iff (reset_in)
      $changed(sda_oe_out) |-> !$past(scl_in, 2)) else $error("sda moved too early");
  stop_release_a:
    assert property (@(posedge link_clk_in) disable iff (reset_in)
      scl_in && $rose(sda_in) |-> sda_oe_out [*8]) else $error("sda held after stop");
  start_release_a:
    assert property (@(posedge link_clk_in) disable iff (reset_in)
      scl_in && $fell(sda_in) |-> sda_oe_out [*8]) else $error("sda held after start");
  busy_quiet_a:
    assert property (@(posedge clk_sys_in) disable iff (reset_in)
      prog_busy_out |-> sda_oe_out) else $error("bus answered while programming");
  prog_idle_a:
    assert property (@(posedge clk_sys_in) disable iff (reset_in)
      $rose(prog_busy_out) |-> scl_in && sda_in) else $error("program began off a stop");
  prog_time_a:
    assert property (@(posedge clk_sys_in) disable iff (reset_in) $fell(prog_busy_out)
      |-> busy_cnt_r inside {[PROG_CYCLES-1:PROG_CYCLES]}) else $error("program time wrong");
endmodule : ee24_slave_properties

bind ee24_slave ee24_slave_properties #(.PROG_CYCLES(PROG_CYCLES)) i_ee24_slave_properties (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .prog_busy_out(prog_busy_out));

//--- tb/test_ee24_slave.sv
// Purpose: self-checking bench of the two-wire serial memory slave
// Assumes: master model paces the bus from the system clock
// Notes:   short program cycle; device type code is arbitrary
`timescale 1ns/1ns
module test_ee24_slave;
  localparam logic [3:0] DEV_T = 4'h6; // arbitrary value
  logic       clk_sys_in, link_clk_in, reset_in;
  logic       strap_lo, strap_hi, wp, scl, m_sda, sda_w, dev_sda, dev_oe, busy, ack;
  logic [7:0] rx;
  logic [7:0] got [16];
  int         err_total, n_compared;

  assign sda_w = m_sda & (dev_oe | dev_sda);

  ee24_slave #(.DEV_TYPE(DEV_T), .PROG_CYCLES(400)) i_ee24_slave (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
    .scl_in(scl), .sda_in(sda_w), .sda_out(dev_sda), .sda_oe_out(dev_oe),
    .strap_addr_bit_low_in(strap_lo), .strap_addr_bit_high_in(strap_hi),
    .write_protect_in(wp), .prog_busy_out(busy));
  ee24_master i_ee24_master (.clk_in(clk_sys_in), .sda_in(sda_w), .scl_out(scl),
    .sda_out(m_sda));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #24 link_clk_in = ~link_clk_in;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  function automatic logic [7:0] sa(input logic blk, input logic rd);
    return {DEV_T, strap_hi, strap_lo, blk, rd};
  endfunction : sa
  task automatic aim(input logic [8:0] a);
    i_ee24_master.start_cond();
    i_ee24_master.xfer(sa(a[8], 1'b0), 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
    i_ee24_master.xfer(a[7:0], 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
  endtask : aim
  task automatic poll;
    bit done;
    done = 1'b0;
    for (int k = 0; k < 8 && !done; k++) begin
      i_ee24_master.start_cond();
      i_ee24_master.xfer(sa(1'b0, 1'b0), 1'b1, rx, ack);
      i_ee24_master.stop_cond();
      if (k == 0) chk({7'h00, ack}, 8'h01);
      done = (ack === 1'b0);
    end
    chk({7'h00, ack}, 8'h00);
    chk({7'h00, busy}, 8'h00);
  endtask : poll
  task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0);
    aim(a);
    for (int i = 0; i < n; i++) begin
      i_ee24_master.xfer(d0 + 8'(i), 1'b1, rx, ack);
      chk({7'h00, ack}, 8'h00);
    end
    i_ee24_master.stop_cond();
    poll();
  endtask : wr
  // last byte is not acknowledged
  task automatic rd(input logic [8:0] a, input logic rnd, input int n);
    if (rnd) aim(a);
    i_ee24_master.start_cond();
    i_ee24_master.xfer(sa(a[8], 1'b1), 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      i_ee24_master.xfer(8'hFF, (i == n - 1), got[i], ack);
    end
    i_ee24_master.stop_cond();
  endtask : rd
  task automatic t_addr;
    logic [7:0] m [3] = '{8'h80, 8'h08, 8'h04};
    foreach (m[k]) begin
      i_ee24_master.start_cond();
      i_ee24_master.xfer(sa(1'b0, 1'b0) ^ m[k], 1'b1, rx, ack);
      chk({7'h00, ack}, 8'h01);
      i_ee24_master.xfer(8'h00, 1'b1, rx, ack);
      chk({7'h00, ack}, 8'h01);
      i_ee24_master.stop_cond();
    end
  endtask : t_addr
  task automatic t_page;
    int s;
    wr(9'h00E, 17, 8'h41);
    rd(9'h000, 1'b1, 16);
    for (int j = 0; j < 16; j++) begin
      s = (j + 2) % 16;
      if (s == 0) s = 16;
      chk(got[j], 8'h41 + 8'(s));
    end
  endtask : t_page
  task automatic t_wrap;
    wr(9'h1FF, 1, 8'hC3);
    rd(9'h1FF, 1'b1, 2);
    chk(got[0], 8'hC3);
    chk(got[1], 8'h43);
    rd(9'h000, 1'b0, 1);
    chk(got[0], 8'h44);
  endtask : t_wrap
  task automatic t_protect;
    wp = 1'b1;
    aim(9'h105);
    i_ee24_master.xfer(8'h5A, 1'b1, rx, ack);
    chk({7'h00, ack}, 8'h01);
    i_ee24_master.stop_cond();
    repeat (20) @(negedge clk_sys_in);
    chk({7'h00, busy}, 8'h00);
    wp = 1'b0;
  endtask : t_protect

  initial begin
    reset_in = 1'b1;
    strap_lo = 1'b1;
    strap_hi = 1'b0;
    wp = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(negedge clk_sys_in);
    reset_in = 1'b0;
    repeat (10) @(negedge clk_sys_in);
    t_addr();
    t_page();
    t_wrap();
    t_protect();
    end_sim();
  end
  initial begin
    #3000000;
    err_total++;
    end_sim();
  end
endmodule : test_ee24_slave
